// *** src/cilg_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module cilg_gate
  import cilg_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  // Register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Direct input pins and variant strap
  input  wire logic [7:0] DIRECT_PINS,
  input  wire logic       LATHE_VARIANT,
  input  wire logic       MANUAL_MODE,
  // Motion side
  output logic      [3:0] AXIS_PLUS_OK,
  output logic      [3:0] AXIS_MINUS_OK,
  output logic      [7:0] AXIS_COORD_UPDATE_OK,
  output logic     [15:0] JOG_RATE,
  output logic            HOLD_DIAG,
  // Interrupt
  output logic            IRQ
);
  logic [7:0]  select_ff, global_ff, axis_ff, plus_ff, minus_ff;
  logic [7:0]  jog_lo_ff, jog_hi_ff, alllock_ff, axlock_ff;
  logic [7:0]  direct_s1_ff, direct_s2_ff;
  logic        lathe_s1_ff, lathe_s2_ff, manual_s1_ff, manual_s2_ff;
  logic [7:0]  irq_st_ff, irq_msk_ff;
  logic [3:0]  nxt_plus_ok, nxt_minus_ok;
  logic [7:0]  nxt_coord_ok;
  logic [15:0] nxt_rate;
  logic        nxt_hold;
  logic [15:0] jog_word;
  logic [7:0]  nxt_rdata;
  logic [2:0]  evt;
  logic        hold_d_ff, jog0_d_ff, frz_d_ff;

  // Pins are asynchronous: two flops before any use
  always_ff @(posedge CORE_CLK) begin
    direct_s1_ff <= DIRECT_PINS;
    direct_s2_ff <= direct_s1_ff;
    lathe_s1_ff  <= LATHE_VARIANT;
    lathe_s2_ff  <= lathe_s1_ff;
    manual_s1_ff <= MANUAL_MODE;
    manual_s2_ff <= manual_s1_ff;
  end

  // Register writes; reset leaves every hold inactive
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      select_ff  <= RST_ZERO;
      global_ff  <= RST_ONES;
      axis_ff    <= RST_ONES;
      plus_ff    <= RST_ZERO;
      minus_ff   <= RST_ZERO;
      jog_lo_ff  <= RST_ONES;
      jog_hi_ff  <= RST_ONES;
      alllock_ff <= RST_ZERO;
      axlock_ff  <= RST_ZERO;
      irq_msk_ff <= RST_ZERO;
    end else if (REG_WR) begin
      if (REG_ADDR == OFS_SELECT) select_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_GLOBAL) global_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_AXIS) axis_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_PLUS) plus_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_MINUS) minus_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_JOG_LO) jog_lo_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_JOG_HI) jog_hi_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_ALLLOCK) alllock_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_AXLOCK) axlock_ff <= REG_WDATA;
      else if (REG_ADDR == OFS_IRQ_MSK) irq_msk_ff <= REG_WDATA;
    end
  end

  // Low byte first, bit 0 of low byte is the LSB
  assign jog_word = {jog_hi_ff, jog_lo_ff};

  // Hold and freeze evaluation; unused inputs rely on inactive levels
  always_comb begin
    logic g_hold;
    logic lathe_dir;
    g_hold    = 1'b0;
    lathe_dir = 1'b0;
    nxt_hold  = 1'b0;
    // Select bits are active low: a cleared bit honours its group
    g_hold = !select_ff[SEL_GLOBAL_BIT] && !global_ff[GLOBAL_BIT];
    lathe_dir = lathe_s2_ff && manual_s2_ff;
    for (int a = 0; a < NUM_HOLD_AXES; a++) begin
      logic ax_hold, p_hold, m_hold;
      ax_hold = 1'b0;
      p_hold  = 1'b0;
      m_hold  = 1'b0;
      ax_hold = !select_ff[SEL_AXIS_BIT] && !axis_ff[a];
      if (!select_ff[SEL_DIR_BIT]) begin
        if (lathe_s2_ff) begin
          // Lathe: axes one and two only, from direct pins
          if (a < 2 && lathe_dir) begin
            p_hold = direct_s2_ff[DIRECT_LO + 2*a];
            m_hold = direct_s2_ff[DIRECT_LO + 2*a + 1];
          end
        end else begin
          p_hold = plus_ff[a];
          m_hold = minus_ff[a];
        end
      end
      nxt_plus_ok[a]  = !(g_hold || ax_hold || p_hold);
      nxt_minus_ok[a] = !(g_hold || ax_hold || m_hold);
      nxt_hold = nxt_hold || g_hold || ax_hold || p_hold || m_hold;
    end
    for (int n = 0; n < NUM_LOCK_AXES; n++) begin
      // Freeze is active high
      nxt_coord_ok[n] = !(alllock_ff[ALLLOCK_BIT] || axlock_ff[n]);
    end
  end

  // Inverted word, 0.01 percent per step; both extremes mean zero
  always_comb begin
    if (jog_word == JOG_ZERO_ONES || jog_word == JOG_ZERO_ZEROS) begin
      nxt_rate = JOG_ZERO_ZEROS;
    end else begin
      nxt_rate = ~jog_word;
    end
  end

  // Registered motion-side outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      AXIS_PLUS_OK         <= 4'hf;
      AXIS_MINUS_OK        <= 4'hf;
      AXIS_COORD_UPDATE_OK <= 8'hff;
      JOG_RATE             <= JOG_ZERO_ZEROS;
      HOLD_DIAG            <= 1'b0;
    end else begin
      AXIS_PLUS_OK         <= nxt_plus_ok;
      AXIS_MINUS_OK        <= nxt_minus_ok;
      AXIS_COORD_UPDATE_OK <= nxt_coord_ok;
      JOG_RATE             <= nxt_rate;
      HOLD_DIAG            <= nxt_hold;
    end
  end

  // Rising-edge events: hold, zero jog rate, any freeze
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      hold_d_ff <= 1'b0;
      jog0_d_ff <= 1'b1; // Rate is zero after reset: no false event
      frz_d_ff  <= 1'b0;
    end else begin
      hold_d_ff <= nxt_hold;
      jog0_d_ff <= (nxt_rate == JOG_ZERO_ZEROS);
      frz_d_ff  <= !(&nxt_coord_ok);
    end
  end
  assign evt = {!(&nxt_coord_ok) && !frz_d_ff,
                (nxt_rate == JOG_ZERO_ZEROS) && !jog0_d_ff,
                nxt_hold && !hold_d_ff};

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_st_ff <= RST_ZERO;
    end else begin
      logic [7:0] clr;
      clr = (REG_WR && REG_ADDR == OFS_IRQ_ST) ? REG_WDATA : RST_ZERO;
      irq_st_ff <= (irq_st_ff & ~clr) | {5'h00, evt};
    end
  end
  assign IRQ = |(irq_st_ff & irq_msk_ff);

  // Read decode
  always_comb begin
    if (REG_ADDR == OFS_SELECT) nxt_rdata = select_ff;
    else if (REG_ADDR == OFS_GLOBAL) nxt_rdata = global_ff;
    else if (REG_ADDR == OFS_AXIS) nxt_rdata = axis_ff;
    else if (REG_ADDR == OFS_PLUS) nxt_rdata = plus_ff;
    else if (REG_ADDR == OFS_MINUS) nxt_rdata = minus_ff;
    else if (REG_ADDR == OFS_DIRECT) nxt_rdata = direct_s2_ff;
    else if (REG_ADDR == OFS_JOG_LO) nxt_rdata = jog_lo_ff;
    else if (REG_ADDR == OFS_JOG_HI) nxt_rdata = jog_hi_ff;
    else if (REG_ADDR == OFS_ALLLOCK) nxt_rdata = alllock_ff;
    else if (REG_ADDR == OFS_AXLOCK) nxt_rdata = axlock_ff;
    else if (REG_ADDR == OFS_STATUS) nxt_rdata = {7'h00, HOLD_DIAG};
    else if (REG_ADDR == OFS_IRQ_ST) nxt_rdata = irq_st_ff;
    else if (REG_ADDR == OFS_IRQ_MSK) nxt_rdata = irq_msk_ff;
    else if (REG_ADDR == OFS_RATE_LO) nxt_rdata = JOG_RATE[7:0];
    else if (REG_ADDR == OFS_RATE_HI) nxt_rdata = JOG_RATE[15:8];
    else nxt_rdata = RST_ZERO;
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) REG_RDATA <= RST_ZERO;
    else REG_RDATA <= REG_RD ? nxt_rdata : RST_ZERO;
  end

  // Checks
  sequence glob_hold_s;
    !select_ff[SEL_GLOBAL_BIT] && !global_ff[GLOBAL_BIT];
  endsequence
  global_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    glob_hold_s |=> (AXIS_PLUS_OK == 4'h0) && (AXIS_MINUS_OK == 4'h0))
    else $error("global hold did not stop motion");
  axis_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !select_ff[SEL_AXIS_BIT] && !axis_ff[0] |=> !AXIS_PLUS_OK[0] && !AXIS_MINUS_OK[0])
    else $error("axis hold did not stop axis one");
  dir_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !select_ff[SEL_DIR_BIT] && !lathe_s2_ff && plus_ff[1] |=> !AXIS_PLUS_OK[1])
    else $error("plus hold did not stop axis two");
  select_off_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    select_ff == RST_ONES |=> AXIS_PLUS_OK == 4'hf)
    else $error("deselected holds still act");
  lathe_auto_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    lathe_s2_ff && !manual_s2_ff && select_ff == 8'hf7 |=> AXIS_MINUS_OK == 4'hf)
    else $error("lathe direction hold outside manual");
  jog_zero_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    jog_word == JOG_ZERO_ZEROS |=> JOG_RATE == JOG_ZERO_ZEROS)
    else $error("all zeros jog word not zero");
  jog_val_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    jog_word == 16'hd8ef |=> JOG_RATE == 16'h2710)
    else $error("hundred percent pattern wrong");
  all_lock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    alllock_ff[ALLLOCK_BIT] |=> AXIS_COORD_UPDATE_OK == 8'h00)
    else $error("all-axes freeze ignored");
  axis_lock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !alllock_ff[ALLLOCK_BIT] |=> AXIS_COORD_UPDATE_OK == ~$past(axlock_ff))
    else $error("per-axis freeze mismatch");
  diag_flag_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (AXIS_PLUS_OK != 4'hf) |-> HOLD_DIAG)
    else $error("hold without diagnostic flag");
endmodule
`default_nettype wire

// *** src/cilg_pkg.sv ***
package cilg_pkg;
  // Register offsets
  localparam logic [3:0] OFS_SELECT  = 4'h0;
  localparam logic [3:0] OFS_GLOBAL  = 4'h1;
  localparam logic [3:0] OFS_AXIS    = 4'h2;
  localparam logic [3:0] OFS_PLUS    = 4'h3;
  localparam logic [3:0] OFS_MINUS   = 4'h4;
  localparam logic [3:0] OFS_DIRECT  = 4'h5;
  localparam logic [3:0] OFS_JOG_LO  = 4'h6;
  localparam logic [3:0] OFS_JOG_HI  = 4'h7;
  localparam logic [3:0] OFS_ALLLOCK = 4'h8;
  localparam logic [3:0] OFS_AXLOCK  = 4'h9;
  localparam logic [3:0] OFS_STATUS  = 4'ha;
  localparam logic [3:0] OFS_IRQ_ST  = 4'hb;
  localparam logic [3:0] OFS_IRQ_MSK = 4'hc;
  localparam logic [3:0] OFS_RATE_LO = 4'hd;
  localparam logic [3:0] OFS_RATE_HI = 4'he;
  // Field positions
  localparam int SEL_GLOBAL_BIT = 0;
  localparam int SEL_AXIS_BIT   = 2;
  localparam int SEL_DIR_BIT    = 3;
  localparam int GLOBAL_BIT     = 0;
  localparam int ALLLOCK_BIT    = 1;
  localparam int DIRECT_LO      = 2;
  localparam int NUM_HOLD_AXES  = 4;
  localparam int NUM_LOCK_AXES  = 8;
  // Reset values: every hold inactive
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_ONES  = 8'hff;
  localparam logic [15:0] JOG_ZERO_ONES  = 16'hffff;
  localparam logic [15:0] JOG_ZERO_ZEROS = 16'h0000;
  // Interrupt bits
  localparam int IRQ_HOLD_BIT = 0;
  localparam int IRQ_JOG0_BIT = 1;
  localparam int IRQ_FRZ_BIT  = 2;
endpackage

// *** sim/cilg_plc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Machine-side controller: drives the direct pins and the mode straps
module cilg_plc_model (
  // Requests from the bench
  input  wire logic       lathe_req,
  input  wire logic       manual_req,
  input  wire logic [3:0] dir_req,
  // Pins into the gate
  output logic      [7:0] DIRECT_PINS,
  output logic            LATHE_VARIANT,
  output logic            MANUAL_MODE
);
  // Direction holds on bits 2 to 5; spare bits parked at their idle low level
  assign DIRECT_PINS   = {2'b00, dir_req, 2'b00};
  assign LATHE_VARIANT = lathe_req;
  assign MANUAL_MODE   = manual_req;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cilg_pkg::*;
  logic        core_clk, sys_rst, reg_wr, reg_rd, lathe, manual, hold_diag, irq;
  logic [3:0]  reg_addr, dir_req, plus_ok, minus_ok;
  logic [7:0]  reg_wdata, rdata, coord_ok, pins;
  logic [15:0] jog_rate;
  logic        lv, mm;
  int          n_fail, n_compared;

  cilg_plc_model plc (.lathe_req(lathe), .manual_req(manual), .dir_req(dir_req),
    .DIRECT_PINS(pins), .LATHE_VARIANT(lv), .MANUAL_MODE(mm));
  cilg_gate dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .DIRECT_PINS(pins), .LATHE_VARIANT(lv), .MANUAL_MODE(mm), .AXIS_PLUS_OK(plus_ok),
    .AXIS_MINUS_OK(minus_ok), .AXIS_COORD_UPDATE_OK(coord_ok), .JOG_RATE(jog_rate),
    .HOLD_DIAG(hold_diag), .IRQ(irq));

  // 100 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single-cycle strobes, changed just after the edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
  endtask

  // Register change lands, then the motion outputs one cycle later
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic outs(input logic [3:0] p, input logic [3:0] m, input logic [7:0] c);
    settle;
    chk("plus_ok", {12'h000, p}, {12'h000, plus_ok});
    chk("minus_ok", {12'h000, m}, {12'h000, minus_ok});
    chk("coord_ok", {8'h00, c}, {8'h00, coord_ok});
  endtask

  task automatic t_reset;
    outs(4'hf, 4'hf, 8'hff);
    chk("hold_diag", 16'h0000, {15'h0000, hold_diag});
    chk("jog_rate", 16'h0000, jog_rate);
    rd(OFS_GLOBAL, 8'hff);
    rd(OFS_AXIS, 8'hff);
    rd(OFS_PLUS, 8'h00);
    rd(OFS_JOG_HI, 8'hff);
  endtask

  // Global hold ignored until selected, then raises a maskable event
  task automatic t_global;
    wr(OFS_IRQ_ST, 8'h07);
    wr(OFS_IRQ_MSK, 8'h01);
    wr(OFS_SELECT, 8'hff);
    wr(OFS_GLOBAL, 8'h00);
    outs(4'hf, 4'hf, 8'hff);
    wr(OFS_SELECT, 8'hfe);
    outs(4'h0, 4'h0, 8'hff);
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(OFS_STATUS, 8'h01);
    rd(OFS_IRQ_ST, 8'h01);
    wr(OFS_IRQ_ST, 8'h01);
    settle;
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(OFS_GLOBAL, 8'hff);
    outs(4'hf, 4'hf, 8'hff);
  endtask

  task automatic t_axis_dir;
    wr(OFS_SELECT, 8'hfb);
    wr(OFS_AXIS, 8'hfa);
    outs(4'ha, 4'ha, 8'hff);
    wr(OFS_SELECT, 8'hf7);
    wr(OFS_PLUS, 8'h01);
    wr(OFS_MINUS, 8'h0c);
    outs(4'he, 4'h3, 8'hff);
    chk("hold_diag", 16'h0001, {15'h0000, hold_diag});
    wr(OFS_PLUS, 8'h08);
    wr(OFS_MINUS, 8'h00);
  endtask

  // Lathe: pins replace the plus/minus bytes, and only in manual mode
  task automatic t_lathe;
    @(posedge core_clk);
    lathe   <= 1'b1;
    manual  <= 1'b1;
    dir_req <= 4'b0110;
    repeat (4) @(posedge core_clk);
    outs(4'hd, 4'he, 8'hff);
    rd(OFS_DIRECT, 8'h18);
    manual <= 1'b0;
    repeat (4) @(posedge core_clk);
    outs(4'hf, 4'hf, 8'hff);
    lathe   <= 1'b0;
    dir_req <= 4'h0;
    wr(OFS_PLUS, 8'h00);
  endtask

  task automatic t_jog;
    logic [15:0] w[5] = '{16'hffff, 16'hfffe, 16'hd8ef, 16'h0001, 16'h0000};
    logic [15:0] e[5] = '{16'h0000, 16'h0001, 16'h2710, 16'hfffe, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      wr(OFS_JOG_LO, w[i][7:0]);
      wr(OFS_JOG_HI, w[i][15:8]);
      settle;
      chk("jog_rate", e[i], jog_rate);
      rd(OFS_RATE_LO, e[i][7:0]);
      rd(OFS_RATE_HI, e[i][15:8]);
    end
  endtask

  // Freezes, then a write and read at the read-only place and a read at an unmapped one
  task automatic t_lock;
    wr(OFS_ALLLOCK, 8'h02);
    outs(4'hf, 4'hf, 8'h00);
    wr(OFS_ALLLOCK, 8'h00);
    wr(OFS_AXLOCK, 8'h81);
    outs(4'hf, 4'hf, 8'h7e);
    wr(OFS_DIRECT, 8'hff);
    rd(OFS_DIRECT, 8'h00);
    rd(4'hf, 8'h00);
  endtask

  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    stop_test;
  end

  initial begin
    n_fail     = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 8'h00;
    lathe      = 1'b0;
    manual     = 1'b0;
    dir_req    = 4'h0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_global;
    t_axis_dir;
    t_lathe;
    t_jog;
    t_lock;
    stop_test;
  end
endmodule
`default_nettype wire
